// File: bec_defs.svh
`ifndef BEC_DEFS_SVH
`define BEC_DEFS_SVH

// indirect register indices
`define BEC_IDX_W          8
`define BEC_IDX_BEAR       8'h00
`define BEC_IDX_BESR0      8'h01
`define BEC_IDX_BESR1      8'h02
`define BEC_IDX_CFG        8'h03

// error type codes
`define BEC_ET_NONE        3'h0
`define BEC_ET_PROT        3'h4
`define BEC_ET_INPUT       3'h6
`define BEC_ET_TMO         3'h7

// master numbers
`define BEC_M_DMA          3'h0
`define BEC_M_ICACHE       3'h1
`define BEC_M_DSIDE        3'h2
`define BEC_M_PCI          3'h4
`define BEC_M_MAL          3'h5

// {type, dir} group base, msb-first bit 0 is bit 31 here
`define BEC_POS_DMA        28
`define BEC_POS_ICACHE     22
`define BEC_POS_DSIDE      16
`define BEC_POS_PCI        28
`define BEC_POS_MAL        22
`define BEC_FL_PCI         27
`define BEC_AL_PCI         26
`define BEC_FL_MAL         21
`define BEC_AL_MAL         20
`define BEC_BESR0_MASK     32'hF3CF0000
`define BEC_BESR1_MASK     32'hFFF00000

// controller configuration layout
`define BEC_CFG_PTD        0
`define BEC_CFG_RTC_LSB    8
`define BEC_RTC_W          8
`define BEC_CFG_RESET      32'h0000FF00

// bank usage codes
`define BEC_BU_RO          2'h1
`define BEC_BU_WO          2'h2

`endif

// File: bec_pkg.sv
package bec_pkg;

  typedef enum logic {
    BEC_IDLE,
    BEC_ACCESS
  } bec_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0]  master;
    logic        read;
    logic        lock;
    logic        dma_periph;
  } bec_req_s;

endpackage : bec_pkg

// File: bec_sync.sv
module bec_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // meta_q feeds only the second stage
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : bec_sync

// File: bec_timeout.sv
module bec_timeout #(
  parameter int unsigned CW = 8
) (
  input  wire logic          sys_clk_in,
  input  wire logic          reset_in,
  input  wire logic          tick_in,
  input  wire logic          clear_in,
  input  wire logic          run_in,
  input  wire logic          addr_change_in,
  input  wire logic [CW-1:0] limit_in,
  output logic               expired_out
);
  logic [CW-1:0] cnt_q;

  // count restarts on every address change; limit 0 never expires
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q       <= '0;
      expired_out <= 1'b0;
    end else if (clear_in || addr_change_in) begin
      cnt_q       <= '0;
      expired_out <= 1'b0;
    end else if (run_in && tick_in && !expired_out) begin
      cnt_q <= CW'(cnt_q + 1'b1);
      // a zero limit would match on wrap-around, so it is kept as never
      if (limit_in != '0 && CW'(cnt_q + 1'b1) == limit_in) begin
        expired_out <= 1'b1;
      end
    end
  end
endmodule : bec_timeout

// File: bec_capture.sv
`include "bec_defs.svh"

module bec_capture #(
  parameter int unsigned PCLK_DIV = 4
) (
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  input  wire logic              dcr_write_in,
  input  wire logic              dcr_read_in,
  input  wire logic              dcr_sel_in,
  input  wire logic [31:0]       dcr_wdata_in,
  output logic      [31:0]       dcr_rdata_out,
  output logic                   dcr_ack_out,
  input  wire logic              req_valid_in,
  input  wire bec_pkg::bec_req_s req_in,
  input  wire logic [1:0]        bank_usage_in,
  input  wire logic              ready_sampling_enable_in,
  input  wire logic              periph_addr_change_in,
  input  wire logic              ext_wait_done_in,
  input  wire logic              periph_ready_in,
  input  wire logic              ext_input_err_in,
  output logic                   req_ready_out,
  output logic                   ext_start_out,
  output logic                   resp_valid_out,
  output logic                   resp_error_out,
  output logic      [2:0]        resp_master_out,
  output logic      [2:0]        resp_type_out
);
  import bec_pkg::*;

  localparam int unsigned RTC_W = `BEC_RTC_W;
  localparam int unsigned DIV_W = (PCLK_DIV > 1) ? $clog2(PCLK_DIV) : 1;

  bec_state_e              state_q;
  bec_req_s                cur_q;
  bec_req_s                log_req;
  logic                    re_q;
  logic                    wait_q;
  logic [`BEC_IDX_W-1:0]   index_q;
  logic [31:0]             bear_q;
  logic [31:0]             besr0_q;
  logic [31:0]             besr1_q;
  logic [31:0]             cfg_q;
  logic [31:0]             bear_d;
  logic [31:0]             besr0_d;
  logic [31:0]             besr1_d;
  logic [DIV_W-1:0]        div_q;
  logic                    tick_q;
  logic                    rdy_s;
  logic                    ierr_s;
  logic                    tmo;
  logic                    tmo_run;
  logic                    accept;
  logic                    prot_hit;
  logic                    acc_ok;
  logic                    log_en;
  logic [2:0]              log_code;
  logic                    al_held;
  logic                    idx_wr;
  logic                    dat_wr;
  logic                    paced_timeout_disable;

  function automatic logic prot_viol(input logic [1:0] bu, input logic rd);
    return (!rd && bu == `BEC_BU_RO) || (rd && bu == `BEC_BU_WO);
  endfunction : prot_viol

  function automatic logic lockable(input logic [2:0] m);
    return (m == `BEC_M_PCI) || (m == `BEC_M_MAL);
  endfunction : lockable

  function automatic logic known(input logic [2:0] m);
    return lockable(m) || m == `BEC_M_DMA || m == `BEC_M_ICACHE || m == `BEC_M_DSIDE;
  endfunction : known

  function automatic int unsigned fld_pos(input logic [2:0] m);
    case (m)
      `BEC_M_ICACHE: return `BEC_POS_ICACHE;
      `BEC_M_DSIDE:  return `BEC_POS_DSIDE;
      `BEC_M_PCI:    return `BEC_POS_PCI;
      `BEC_M_MAL:    return `BEC_POS_MAL;
      default:       return `BEC_POS_DMA;
    endcase
  endfunction : fld_pos

  assign paced_timeout_disable    = cfg_q[`BEC_CFG_PTD];
  assign idx_wr = dcr_write_in && !dcr_sel_in;
  assign dat_wr = dcr_write_in && dcr_sel_in;

  bec_sync #(.W(2)) u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .async_in   ({periph_ready_in, ext_input_err_in}),
    .sync_out   ({rdy_s, ierr_s})
  );

  // peripheral clock rate as an enable pulse
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_W'(PCLK_DIV - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= DIV_W'(div_q + 1'b1);
      tick_q <= 1'b0;
    end
  end

  // timer only when enabled and not on the dma peripheral leg
  assign tmo_run = (state_q == BEC_ACCESS) && re_q && !paced_timeout_disable && !cur_q.dma_periph;

  bec_timeout #(.CW(RTC_W)) u_timeout (
    .sys_clk_in     (sys_clk_in),
    .reset_in       (reset_in),
    .tick_in        (tick_q),
    .clear_in       (accept),
    .run_in         (tmo_run),
    .addr_change_in (periph_addr_change_in),
    .limit_in       (cfg_q[`BEC_CFG_RTC_LSB +: RTC_W]),
    .expired_out    (tmo)
  );

  // nothing taken in the first cycle after reset, while ready is still low
  assign prot_hit = (state_q == BEC_IDLE) && req_valid_in && req_ready_out
                    && prot_viol(bank_usage_in, req_in.read);
  assign accept   = (state_q == BEC_IDLE) && req_valid_in && req_ready_out && !prot_hit;
  // ready ignored when sampling off; with ptd set the wait has no bound
  assign acc_ok   = wait_q && (!re_q || rdy_s);

  always_comb begin
    log_en   = 1'b0;
    log_code = `BEC_ET_NONE;
    log_req  = cur_q;
    if (prot_hit) begin
      log_en   = 1'b1;
      log_code = `BEC_ET_PROT;
      log_req  = req_in;
    end else if (state_q == BEC_ACCESS) begin
      if (ierr_s) begin
        log_en   = 1'b1;
        log_code = `BEC_ET_INPUT;
      end else if (tmo && tmo_run) begin
        log_en   = 1'b1;
        log_code = `BEC_ET_TMO;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q         <= BEC_IDLE;
      cur_q           <= '0;
      re_q            <= 1'b0;
      wait_q          <= 1'b0;
      req_ready_out   <= 1'b0;
      ext_start_out   <= 1'b0;
      resp_valid_out  <= 1'b0;
      resp_error_out  <= 1'b0;
      resp_master_out <= '0;
      resp_type_out   <= `BEC_ET_NONE;
    end else begin
      ext_start_out  <= 1'b0;
      resp_valid_out <= 1'b0;
      resp_error_out <= 1'b0;
      case (state_q)
        BEC_IDLE: begin
          req_ready_out <= 1'b1;
          wait_q        <= 1'b0;
          if (prot_hit) begin
            // no external cycle for a protection error
            resp_valid_out  <= 1'b1;
            resp_error_out  <= 1'b1;
            resp_master_out <= req_in.master;
            resp_type_out   <= `BEC_ET_PROT;
          end else if (accept) begin
            state_q       <= BEC_ACCESS;
            cur_q         <= req_in;
            re_q          <= ready_sampling_enable_in;
            ext_start_out <= 1'b1;
            req_ready_out <= 1'b0;
          end
        end
        BEC_ACCESS: begin
          if (ext_wait_done_in) begin
            wait_q <= 1'b1;
          end
          if (log_en || acc_ok) begin
            state_q         <= BEC_IDLE;
            req_ready_out   <= 1'b1;
            resp_valid_out  <= 1'b1;
            resp_error_out  <= log_en;
            resp_master_out <= cur_q.master;
            resp_type_out   <= log_en ? log_code : `BEC_ET_NONE;
          end
        end
        default: state_q <= BEC_IDLE;
      endcase
    end
  end

  // software write first, error logging on top so a same-cycle event wins
  always_comb begin
    besr0_d = besr0_q;
    besr1_d = besr1_q;
    bear_d  = bear_q;
    al_held = 1'b0;
    if (dat_wr && index_q == `BEC_IDX_BESR0) begin
      besr0_d = dcr_wdata_in & `BEC_BESR0_MASK;
    end
    if (dat_wr && index_q == `BEC_IDX_BESR1) begin
      besr1_d = dcr_wdata_in & `BEC_BESR1_MASK;
    end
    al_held = besr1_d[`BEC_AL_PCI] || besr1_d[`BEC_AL_MAL];
    if (log_en && known(log_req.master)) begin
      if (lockable(log_req.master)) begin
        if (log_req.master == `BEC_M_PCI) begin
          if (!besr1_d[`BEC_FL_PCI]) begin
            besr1_d[`BEC_POS_PCI +: 4] = {log_code, log_req.read};
          end
          if (log_req.lock) begin
            besr1_d[`BEC_FL_PCI] = 1'b1;
            besr1_d[`BEC_AL_PCI] = besr1_d[`BEC_AL_PCI] || !al_held;
          end
        end else begin
          if (!besr1_d[`BEC_FL_MAL]) begin
            besr1_d[`BEC_POS_MAL +: 4] = {log_code, log_req.read};
          end
          if (log_req.lock) begin
            besr1_d[`BEC_FL_MAL] = 1'b1;
            besr1_d[`BEC_AL_MAL] = besr1_d[`BEC_AL_MAL] || !al_held;
          end
        end
      end else begin
        besr0_d[fld_pos(log_req.master) +: 4] = {log_code, log_req.read};
      end
      if (!al_held) begin
        bear_d = log_req.addr;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bear_q  <= '0;
      besr0_q <= '0;
      besr1_q <= '0;
    end else begin
      bear_q  <= bear_d;
      besr0_q <= besr0_d;
      besr1_q <= besr1_d;
    end
  end

  // indirect access: index register, then data register
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      index_q       <= '0;
      cfg_q         <= `BEC_CFG_RESET;
      dcr_rdata_out <= '0;
      dcr_ack_out   <= 1'b0;
    end else begin
      dcr_ack_out <= dcr_write_in || dcr_read_in;
      if (idx_wr) begin
        index_q <= dcr_wdata_in[`BEC_IDX_W-1:0];
      end
      if (dat_wr && index_q == `BEC_IDX_CFG) begin
        cfg_q <= dcr_wdata_in;
      end
      if (dcr_read_in) begin
        if (!dcr_sel_in) begin
          dcr_rdata_out <= {{(32-`BEC_IDX_W){1'b0}}, index_q};
        end else if (index_q == `BEC_IDX_BEAR) begin
          dcr_rdata_out <= bear_q;
        end else if (index_q == `BEC_IDX_BESR0) begin
          dcr_rdata_out <= besr0_q;
        end else if (index_q == `BEC_IDX_BESR1) begin
          dcr_rdata_out <= besr1_q;
        end else if (index_q == `BEC_IDX_CFG) begin
          dcr_rdata_out <= cfg_q;
        end else begin
          dcr_rdata_out <= '0;
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  a_prot_no_start: assert property (prot_hit |=> !ext_start_out && resp_error_out
    && resp_type_out == `BEC_ET_PROT)
    else $error("protection error started an external cycle");
  a_tmo_enable: assert property (log_en && log_code == `BEC_ET_TMO |-> re_q && !paced_timeout_disable)
    else $error("timeout without ready sampling and timeout enabled");
  a_tmo_no_dma: assert property (log_en && log_code == `BEC_ET_TMO
    |-> !cur_q.dma_periph)
    else $error("timeout during dma peripheral leg");
  a_err_report: assert property (log_en |=> resp_valid_out && resp_error_out
    && resp_master_out == $past(log_req.master) && resp_type_out == $past(log_code))
    else $error("error not reported to initiating master");
  a_dir_logged: assert property (log_en && log_req.master == `BEC_M_DSIDE
    |=> besr0_q[`BEC_POS_DSIDE +: 4] == {$past(log_code), $past(log_req.read)})
    else $error("data side type or direction not logged");
  a_field_frozen: assert property (besr1_q[`BEC_FL_PCI]
    && !(dat_wr && index_q == `BEC_IDX_BESR1) |=> $stable(besr1_q[`BEC_POS_PCI +: 4]))
    else $error("locked field overwritten");
  a_addr_frozen: assert property ((besr1_q[`BEC_AL_PCI] || besr1_q[`BEC_AL_MAL])
    && !(dat_wr && index_q == `BEC_IDX_BESR1) |=> $stable(bear_q))
    else $error("locked error address overwritten");
  a_lock_sets: assert property (log_en && log_req.lock && log_req.master == `BEC_M_MAL
    |=> besr1_q[`BEC_FL_MAL])
    else $error("field lock not set on locked error");
  a_clear_release: assert property (dat_wr && index_q == `BEC_IDX_BESR1 && !log_en
    |=> besr1_q == ($past(dcr_wdata_in) & `BEC_BESR1_MASK))
    else $error("status write not applied");
  a_ptd_wait: assert property (state_q == BEC_ACCESS && re_q && paced_timeout_disable && !rdy_s
    && !ierr_s |=> state_q == BEC_ACCESS)
    else $error("left access without ready while timeout disabled");

  c_prot: cover property (prot_hit ##1 resp_error_out);
  c_tmo: cover property (log_en && log_code == `BEC_ET_TMO);
  c_locked_twice: cover property (besr1_q[`BEC_AL_PCI] && log_en
    && log_req.master == `BEC_M_MAL);
  c_clean: cover property (ext_start_out ##[1:50] resp_valid_out && !resp_error_out);
endmodule : bec_capture

// File: bec_master_model.sv
module bec_master_model #(
  parameter int unsigned WAIT = 2
) (
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  input  wire logic              req_ready_in,
  input  wire logic              ext_start_in,
  input  wire logic              resp_valid_in,
  input  wire logic [7:0]        rdy_lat_in,
  output logic                   req_valid_out,
  output bec_pkg::bec_req_s      req_out,
  output logic                   addr_change_out,
  output logic                   wait_done_out,
  output logic                   periph_ready_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import bec_pkg::*;

  logic [7:0] wcnt_q;
  logic [7:0] rcnt_q;
  logic       wact_q;
  logic       ract_q;

  initial begin
    req_valid_out = 1'b0;
    req_out       = '0;
  end

  // request held until ready is sampled high
  task automatic send(input bec_req_s r);
    @(posedge sys_clk_in);
    req_valid_out <= 1'b1;
    req_out       <= r;
    do @(posedge sys_clk_in); while (req_ready_in !== 1'b1);
    req_valid_out <= 1'b0;
    // released bus shows no stale request
    req_out       <= ~r;
  endtask : send

  // external side: wait states, then ready after rdy_lat_in (8'hFF never)
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wcnt_q           <= 8'h00;
      rcnt_q           <= 8'h00;
      wact_q           <= 1'b0;
      ract_q           <= 1'b0;
      addr_change_out  <= 1'b0;
      wait_done_out    <= 1'b0;
      periph_ready_out <= 1'b0;
    end else begin
      addr_change_out <= ext_start_in;
      wait_done_out   <= 1'b0;
      if (ext_start_in) begin
        wact_q <= 1'b1;
        wcnt_q <= 8'(WAIT);
      end else if (wact_q) begin
        if (wcnt_q == 8'h00) begin
          wait_done_out <= 1'b1;
          wact_q        <= 1'b0;
          ract_q        <= 1'b1;
          rcnt_q        <= rdy_lat_in;
        end else begin
          wcnt_q <= wcnt_q - 8'h01;
        end
      end
      if (ract_q && rdy_lat_in != 8'hFF) begin
        if (rcnt_q == 8'h00) begin
          periph_ready_out <= 1'b1;
        end else begin
          rcnt_q <= rcnt_q - 8'h01;
        end
      end
      if (resp_valid_in) begin
        periph_ready_out <= 1'b0;
        ract_q           <= 1'b0;
        wact_q           <= 1'b0;
      end
    end
  end
endmodule : bec_master_model

// File: bec_capture_bench.sv
`include "bec_defs.svh"

module bec_capture_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import bec_pkg::*;

  typedef struct packed {
    logic [2:0] m;
    logic       rd;
    logic [1:0] bu;
    logic       re;
    logic       ierr;
    logic [7:0] rdy;
    logic [2:0] et;
  } bec_row_s;

  localparam bec_row_s ROWS [0:5] = '{
    '{`BEC_M_DMA, 1'b0, `BEC_BU_RO, 1'b0, 1'b0, 8'hFF, `BEC_ET_PROT},
    '{`BEC_M_ICACHE, 1'b1, `BEC_BU_WO, 1'b0, 1'b0, 8'hFF, `BEC_ET_PROT},
    '{`BEC_M_DSIDE, 1'b1, `BEC_BU_RO, 1'b0, 1'b0, 8'hFF, `BEC_ET_NONE},
    '{`BEC_M_DSIDE, 1'b0, 2'h0, 1'b0, 1'b1, 8'hFF, `BEC_ET_INPUT},
    '{`BEC_M_PCI, 1'b1, 2'h0, 1'b1, 1'b0, 8'hFF, `BEC_ET_TMO},
    '{`BEC_M_MAL, 1'b0, `BEC_BU_WO, 1'b1, 1'b0, 8'h03, `BEC_ET_NONE}};

  logic        sys_clk_in;
  logic        reset_in;
  logic        dcr_write_in;
  logic        dcr_read_in;
  logic        dcr_sel_in;
  logic [31:0] dcr_wdata_in;
  logic [31:0] dcr_rdata_out;
  logic        dcr_ack_out;
  logic        req_valid_in;
  bec_req_s    req_in;
  logic [1:0]  bank_usage_in;
  logic        re_in;
  logic        addr_chg;
  logic        wait_done;
  logic        rdy;
  logic        ierr_in;
  logic [7:0]  rdy_lat;
  logic        req_ready_out;
  logic        ext_start_out;
  logic        resp_valid_out;
  logic        resp_error_out;
  logic [2:0]  resp_master_out;
  logic [2:0]  resp_type_out;
  int          n_fail;
  int          n_checks;
  int          n_start;
  int          n_prev;
  int          n_cyc;
  int          cyc;
  logic [31:0] ea;
  logic [31:0] e1;

  bec_capture #(.PCLK_DIV(2)) dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .dcr_write_in(dcr_write_in),
    .dcr_read_in(dcr_read_in), .dcr_sel_in(dcr_sel_in), .dcr_wdata_in(dcr_wdata_in),
    .dcr_rdata_out(dcr_rdata_out), .dcr_ack_out(dcr_ack_out), .req_valid_in(req_valid_in),
    .req_in(req_in), .bank_usage_in(bank_usage_in), .ready_sampling_enable_in(re_in),
    .periph_addr_change_in(addr_chg), .ext_wait_done_in(wait_done), .periph_ready_in(rdy),
    .ext_input_err_in(ierr_in), .req_ready_out(req_ready_out), .ext_start_out(ext_start_out),
    .resp_valid_out(resp_valid_out), .resp_error_out(resp_error_out),
    .resp_master_out(resp_master_out), .resp_type_out(resp_type_out));

  bec_master_model mdl (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .req_ready_in(req_ready_out),
    .ext_start_in(ext_start_out), .resp_valid_in(resp_valid_out), .rdy_lat_in(rdy_lat),
    .req_valid_out(req_valid_in), .req_out(req_in), .addr_change_out(addr_chg),
    .wait_done_out(wait_done), .periph_ready_out(rdy));

  always #2 sys_clk_in = ~sys_clk_in;

  task automatic summarize();
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // hang guard, run needs under two thousand cycles
  always @(posedge sys_clk_in) begin
    n_cyc++;
    if (ext_start_out === 1'b1) n_start++;
    if (n_cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic device_control_reg_bus(input logic wr, input logic sel, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk_in);
    dcr_write_in <= wr;
    dcr_read_in  <= !wr;
    dcr_sel_in   <= sel;
    dcr_wdata_in <= d;
    @(posedge sys_clk_in);
    dcr_write_in <= 1'b0;
    dcr_read_in  <= 1'b0;
    #1;
    chk("dcr_ack", 32'h1, dcr_ack_out);
    q = dcr_rdata_out;
  endtask : device_control_reg_bus

  task automatic wreg(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    device_control_reg_bus(1'b1, 1'b0, {24'h0, idx}, q);
    device_control_reg_bus(1'b1, 1'b1, d, q);
  endtask : wreg

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] q;
    device_control_reg_bus(1'b1, 1'b0, {24'h0, idx}, q);
    device_control_reg_bus(1'b0, 1'b1, 32'h0, q);
    chk(what, exp, q);
  endtask : rchk

  task automatic setup(input logic [1:0] bu, input logic re, input logic ie, input logic [7:0] rl);
    @(posedge sys_clk_in);
    bank_usage_in <= bu;
    re_in         <= re;
    ierr_in       <= ie;
    rdy_lat       <= rl;
  endtask : setup

  task automatic go(input logic [2:0] m, input logic rd, input logic lk, input logic dp,
                    input logic [31:0] a);
    bec_req_s r;
    r = '{addr: a, master: m, read: rd, lock: lk, dma_periph: dp};
    mdl.send(r);
    cyc = 0;
    // a protection answer stands only in the cycle right after the take
    #1;
    while (resp_valid_out !== 1'b1 && cyc < 3000) begin
      @(posedge sys_clk_in);
      #1;
      cyc++;
    end
    chk("resp_valid", 32'h1, {31'h0, resp_valid_out === 1'b1});
  endtask : go

  function automatic logic [31:0] fld(input logic [2:0] m, input logic [2:0] t, input logic rd);
    int p;
    p = (m == `BEC_M_DMA) ? `BEC_POS_DMA : (m == `BEC_M_PCI) ? `BEC_POS_PCI :
        (m == `BEC_M_ICACHE) ? `BEC_POS_ICACHE : (m == `BEC_M_MAL) ? `BEC_POS_MAL : `BEC_POS_DSIDE;
    return (t == `BEC_ET_NONE) ? 32'h0 : ({28'h0, t, rd} << p);
  endfunction : fld

  initial begin
    sys_clk_in = 1'b0; reset_in = 1'b1; dcr_write_in = 1'b0; dcr_read_in = 1'b0;
    dcr_sel_in = 1'b0; dcr_wdata_in = 32'h0; bank_usage_in = 2'h0; re_in = 1'b0;
    ierr_in = 1'b0; rdy_lat = 8'hFF; n_fail = 0; n_checks = 0; n_start = 0; n_cyc = 0;
    ea = 32'h0;
    repeat (6) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rchk(`BEC_IDX_CFG, `BEC_CFG_RESET, "cfg_reset");
    rchk(`BEC_IDX_BEAR, 32'h0, "bear_reset");
    rchk(`BEC_IDX_BESR0, 32'h0, "besr0_reset");
    rchk(`BEC_IDX_BESR1, 32'h0, "besr1_reset");
    rchk(8'h05, 32'h0, "unmapped");
    chk("ready_idle", 32'h1, {31'h0, req_ready_out});
    for (int i = 0; i < 6; i++) begin
      setup(ROWS[i].bu, ROWS[i].re, ROWS[i].ierr, ROWS[i].rdy);
      wreg(`BEC_IDX_BESR0, 32'h0);
      wreg(`BEC_IDX_BESR1, 32'h0);
      n_prev = n_start;
      go(ROWS[i].m, ROWS[i].rd, 1'b0, 1'b0, 32'hA5C30000 + i);
      chk("ext_start", (ROWS[i].et == `BEC_ET_PROT) ? n_prev : n_prev + 1, n_start);
      chk("resp_error", {31'h0, ROWS[i].et != 3'h0}, resp_error_out);
      chk("resp_type", {29'h0, ROWS[i].et}, resp_type_out);
      chk("resp_master", {29'h0, ROWS[i].m}, resp_master_out);
      if (ROWS[i].et != `BEC_ET_NONE) ea = 32'hA5C30000 + i;
      rchk(`BEC_IDX_BEAR, ea, "bear");
      rchk(ROWS[i].m[2] ? `BEC_IDX_BESR1 : `BEC_IDX_BESR0,
           fld(ROWS[i].m, ROWS[i].et, ROWS[i].rd), "status");
    end
    // locking: first error held, second master gets field lock only
    setup(`BEC_BU_RO, 1'b0, 1'b0, 8'hFF);
    wreg(`BEC_IDX_BESR1, 32'h0);
    go(`BEC_M_PCI, 1'b0, 1'b1, 1'b0, 32'h11110000);
    e1 = fld(`BEC_M_PCI, `BEC_ET_PROT, 1'b0) | (32'h1 << `BEC_FL_PCI) | (32'h1 << `BEC_AL_PCI);
    rchk(`BEC_IDX_BESR1, e1, "lock_pci");
    go(`BEC_M_MAL, 1'b0, 1'b1, 1'b0, 32'h22220000);
    e1 = e1 | fld(`BEC_M_MAL, `BEC_ET_PROT, 1'b0) | (32'h1 << `BEC_FL_MAL);
    rchk(`BEC_IDX_BESR1, e1, "lock_mal");
    setup(2'h0, 1'b0, 1'b1, 8'hFF);
    go(`BEC_M_PCI, 1'b1, 1'b0, 1'b0, 32'h33330000);
    chk("locked_resp", {29'h0, `BEC_ET_INPUT}, resp_type_out);
    rchk(`BEC_IDX_BESR1, e1, "field_frozen");
    go(`BEC_M_DSIDE, 1'b1, 1'b0, 1'b0, 32'h44440000);
    rchk(`BEC_IDX_BESR0, fld(`BEC_M_DSIDE, `BEC_ET_INPUT, 1'b1), "dside_log");
    wreg(`BEC_IDX_BEAR, 32'hFFFFFFFF);
    rchk(`BEC_IDX_BEAR, 32'h11110000, "bear_frozen");
    wreg(`BEC_IDX_BESR1, 32'h0);
    rchk(`BEC_IDX_BESR1, 32'h0, "cleared");
    setup(`BEC_BU_RO, 1'b0, 1'b0, 8'hFF);
    go(`BEC_M_DSIDE, 1'b0, 1'b0, 1'b0, 32'h55550000);
    rchk(`BEC_IDX_BESR0, fld(`BEC_M_DSIDE, `BEC_ET_PROT, 1'b0), "overwrite");
    rchk(`BEC_IDX_BEAR, 32'h55550000, "bear_relock");
    // timeout span, disable flag, dma peripheral side, sampling off
    setup(2'h0, 1'b1, 1'b0, 8'd100);
    wreg(`BEC_IDX_CFG, 32'h00000801);
    go(`BEC_M_PCI, 1'b1, 1'b0, 1'b0, 32'h66660000);
    chk("ptd_wait", {29'h0, `BEC_ET_NONE}, resp_type_out);
    wreg(`BEC_IDX_CFG, 32'h00000800);
    go(`BEC_M_PCI, 1'b1, 1'b0, 1'b0, 32'h77770000);
    chk("tmo_type", {29'h0, `BEC_ET_TMO}, resp_type_out);
    chk("tmo_span", 32'h1, {31'h0, cyc >= 16 && cyc <= 30});
    go(`BEC_M_DMA, 1'b1, 1'b0, 1'b1, 32'h88880000);
    chk("dma_periph", {29'h0, `BEC_ET_NONE}, resp_type_out);
    setup(2'h0, 1'b0, 1'b0, 8'hFF);
    go(`BEC_M_ICACHE, 1'b1, 1'b0, 1'b0, 32'h99990000);
    chk("re_off", 32'h0, {31'h0, resp_error_out});
    // mid-run reset: ready low through reset and its first cycle, registers back to reset
    @(posedge sys_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk("rst_ready", 32'h0, {31'h0, req_ready_out});
    @(posedge sys_clk_in);
    reset_in <= 1'b0;
    #1;
    chk("rel_ready", 32'h0, {31'h0, req_ready_out});
    @(posedge sys_clk_in);
    #1;
    chk("idle_ready", 32'h1, {31'h0, req_ready_out});
    rchk(`BEC_IDX_BEAR, 32'h0, "bear_rst");
    rchk(`BEC_IDX_CFG, `BEC_CFG_RESET, "cfg_rst");
    summarize();
  end
endmodule : bec_capture_bench
